// ---- pkg/probe_defines.svh ----
// Object indexes, control and status bit positions and mode codes of the probe block.
`ifndef PROBE_DEFINES_SVH
`define PROBE_DEFINES_SVH

`define OBJ_POS_OFFSET 16'h60b0
`define OBJ_SPD_OFFSET 16'h60b1
`define OBJ_TRQ_OFFSET 16'h60b2
`define OBJ_CAPTURE_CTRL 16'h60b8
`define OBJ_CAPTURE_STATUS 16'h60b9
`define OBJ_RESULT_FIRST 16'h60ba
`define OBJ_RESULT_LAST 16'h60bd

`define OFFSET_RESET 32'h0000_0000
`define CTRL_RESET 16'h0000

`define PROBE_BIT_STRIDE 8
`define CTRL_ENABLE_BIT 0
`define CTRL_CONTINUOUS_BIT 1
`define CTRL_SOURCE_BIT 2
`define CTRL_RISE_BIT 4
`define CTRL_FALL_BIT 5
`define STAT_ENABLE_BIT 0
`define STAT_RISE_BIT 1
`define STAT_FALL_BIT 2

`define MODE_CYCLIC_SYNC_POSITION 8'h08
`define MODE_CYCLIC_SYNC_VELOCITY 8'h09
`define MODE_CYCLIC_SYNC_TORQUE 8'h0a

`endif

// ---- pkg/probe_pkg.sv ----
// Types shared by the touch probe and setpoint offset block.
package probe_pkg;

	typedef struct packed {
		logic valid;
		logic [15:0] index;
		logic [31:0] data;
	} obj_write_t;

	typedef struct packed {
		logic valid;
		logic [15:0] index;
	} obj_read_t;

	typedef struct packed {
		logic enable;
		logic continuous;
		logic use_index;
		logic rise_en;
		logic fall_en;
	} probe_cfg_t;

endpackage

// ---- verilog/probe_result_mem.sv ----
// Four-word store of captured positions with per-word write enables and registered read.
`timescale 1ns/10ps
`include "probe_defines.svh"

module probe_result_mem (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_wr_en,
	input wire logic [31:0] i_wr_data,
	input wire logic [1:0] i_rd_addr,
	output logic [31:0] o_rd_data
);
	logic [31:0] word_q [4];
	logic [31:0] word_d [4];
	logic [31:0] rd_data_d;

	always_comb begin
		for (int w = 0; w < 4; w++) begin
			word_d[w] = i_wr_en[w] ? i_wr_data : word_q[w];
		end
		rd_data_d = word_q[i_rd_addr];
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int w = 0; w < 4; w++) begin
				word_q[w] <= `OFFSET_RESET;
			end
			o_rd_data <= `OFFSET_RESET;
		end else begin
			for (int w = 0; w < 4; w++) begin
				word_q[w] <= word_d[w];
			end
			o_rd_data <= rd_data_d;
		end
	end
endmodule

// ---- verilog/probe_offsets.sv ----
// Touch probe capture and cyclic setpoint offset block of the servo drive.
// Operation
// - In position mode the effective position target is target plus position offset.
// - In velocity mode the effective speed target is target plus speed offset.
// - In torque mode the effective torque target is target plus torque offset.
// - Three signed 32-bit offsets are writable, readable and reset to zero.
// - The 16-bit capture control word takes any value and resets to zero.
// - Control bits 0 and 8 enable probe one and probe two.
// - Control bits 1 and 9 pick single or continuous capture.
// - Control bits 2 and 10 pick digital input four or encoder index.
// - Control bits 4 and 12 enable capture on a rising trigger edge.
// - Control bits 5 and 13 enable capture on a falling edge, both allowed.
// - Control bits 3, 6, 7, 11, 14 and 15 have no effect.
// - A qualifying edge stores current position feedback in that probe's edge result.
// - Status word shows enables in bits 0, 8 and latched edges in 1, 2, 9, 10.
`timescale 1ns/10ps
`include "probe_defines.svh"

module probe_offsets (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire probe_pkg::obj_write_t i_obj_wr,
	input wire probe_pkg::obj_read_t i_obj_rd,
	input wire logic [7:0] i_op_mode,
	input wire logic signed [31:0] i_target_position,
	input wire logic signed [31:0] i_target_velocity,
	input wire logic signed [31:0] i_target_torque,
	input wire logic signed [31:0] i_position_feedback,
	input wire logic i_digital_input_four,
	input wire logic i_encoder_index,
	output logic signed [31:0] o_eff_position,
	output logic signed [31:0] o_eff_speed,
	output logic signed [31:0] o_eff_torque,
	output logic [15:0] o_probe_status,
	output logic o_obj_rd_valid,
	output logic [31:0] o_obj_rd_data
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// Control bits that are not decoded here are stored but never read by probe logic.
	function automatic probe_pkg::probe_cfg_t cfg_of(input logic [15:0] w, input int p);
		probe_pkg::probe_cfg_t c;
		logic [7:0] half;
		half = p[0] ? w[15:8] : w[7:0];
		c.enable = half[`CTRL_ENABLE_BIT];
		c.continuous = half[`CTRL_CONTINUOUS_BIT];
		c.use_index = half[`CTRL_SOURCE_BIT];
		c.rise_en = half[`CTRL_RISE_BIT];
		c.fall_en = half[`CTRL_FALL_BIT];
		return c;
	endfunction

	// Object registers written from received process data.
	logic signed [31:0] pos_off_q, pos_off_d, spd_off_q, spd_off_d, trq_off_q, trq_off_d;
	logic [15:0] ctrl_q, ctrl_d;

	always_comb begin
		pos_off_d = pos_off_q;
		spd_off_d = spd_off_q;
		trq_off_d = trq_off_q;
		ctrl_d = ctrl_q;
		if (i_obj_wr.valid) begin
			unique case (i_obj_wr.index)
				`OBJ_POS_OFFSET: pos_off_d = i_obj_wr.data;
				`OBJ_SPD_OFFSET: spd_off_d = i_obj_wr.data;
				`OBJ_TRQ_OFFSET: trq_off_d = i_obj_wr.data;
				`OBJ_CAPTURE_CTRL: ctrl_d = i_obj_wr.data[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pos_off_q <= `OFFSET_RESET;
			spd_off_q <= `OFFSET_RESET;
			trq_off_q <= `OFFSET_RESET;
			ctrl_q <= `CTRL_RESET;
		end else begin
			pos_off_q <= pos_off_d;
			spd_off_q <= spd_off_d;
			trq_off_q <= trq_off_d;
			ctrl_q <= ctrl_d;
		end
	end

	chk_offset_write: assert property (i_obj_wr.valid && i_obj_wr.index == `OBJ_POS_OFFSET
		|=> pos_off_q == $past(i_obj_wr.data)) else $error("position offset not stored");
	chk_ctrl_write: assert property (i_obj_wr.valid && i_obj_wr.index == `OBJ_CAPTURE_CTRL
		|=> ctrl_q == $past(i_obj_wr.data[15:0])) else $error("control word not stored");

	// Effective targets; outside its own mode each offset is left out.
	logic signed [31:0] eff_pos_d, eff_spd_d, eff_trq_d;

	always_comb begin
		eff_pos_d = i_target_position;
		eff_spd_d = i_target_velocity;
		eff_trq_d = i_target_torque;
		if (i_op_mode == `MODE_CYCLIC_SYNC_POSITION) begin
			eff_pos_d = i_target_position + pos_off_q;
		end
		if (i_op_mode == `MODE_CYCLIC_SYNC_VELOCITY) begin
			eff_spd_d = i_target_velocity + spd_off_q;
		end
		if (i_op_mode == `MODE_CYCLIC_SYNC_TORQUE) begin
			eff_trq_d = i_target_torque + trq_off_q;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_eff_position <= `OFFSET_RESET;
			o_eff_speed <= `OFFSET_RESET;
			o_eff_torque <= `OFFSET_RESET;
		end else begin
			o_eff_position <= eff_pos_d;
			o_eff_speed <= eff_spd_d;
			o_eff_torque <= eff_trq_d;
		end
	end

	sequence s_pos_mode;
		i_op_mode == `MODE_CYCLIC_SYNC_POSITION;
	endsequence
	sequence s_vel_mode;
		i_op_mode == `MODE_CYCLIC_SYNC_VELOCITY;
	endsequence
	sequence s_trq_mode;
		i_op_mode == `MODE_CYCLIC_SYNC_TORQUE;
	endsequence

	chk_pos_target_sum: assert property (s_pos_mode |=>
		o_eff_position == $past(i_target_position) + $past(pos_off_q))
		else $error("position target is not target plus offset");
	chk_speed_target_sum: assert property (s_vel_mode |=>
		o_eff_speed == $past(i_target_velocity) + $past(spd_off_q))
		else $error("speed target is not target plus offset");
	chk_torque_target_sum: assert property (s_trq_mode |=>
		o_eff_torque == $past(i_target_torque) + $past(trq_off_q))
		else $error("torque target is not target plus offset");

	// Trigger inputs: source 0 is digital input four, source 1 the encoder index.
	// A change is taken only once the second and third stages agree, which rejects
	// a single-cycle glitch at the cost of one cycle of latency.
	logic [1:0] pin_raw;
	logic [1:0] sync1_q, sync2_q, sync3_q, level_q, level_d;
	logic [1:0] src_rise, src_fall;

	assign pin_raw = {i_encoder_index, i_digital_input_four};

	generate
		for (genvar s = 0; s < 2; s++) begin : g_src
			always_comb begin
				level_d[s] = level_q[s];
				src_rise[s] = 1'b0;
				src_fall[s] = 1'b0;
				if (sync2_q[s] == sync3_q[s] && sync3_q[s] != level_q[s]) begin
					level_d[s] = sync3_q[s];
					src_rise[s] = sync3_q[s];
					src_fall[s] = !sync3_q[s];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
			level_q <= 2'h0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			level_q <= level_d;
		end
	end

	chk_edge_needs_agree: assert property (src_rise[0] |-> $past(pin_raw[0], 2)
		&& $past(pin_raw[0], 3) && !level_q[0]) else $error("input edge taken too early");

	// Probe capture: wr_en bit 2p is the rising result, 2p+1 the falling result.
	probe_pkg::probe_cfg_t cfg [2];
	logic [1:0] done_q, done_d, rise_lat_q, rise_lat_d, fall_lat_q, fall_lat_d;
	logic [3:0] wr_en;
	logic [15:0] status_d;

	generate
		for (genvar p = 0; p < 2; p++) begin : g_probe
			logic armed;
			logic trig_rise;
			logic trig_fall;
			always_comb begin
				cfg[p] = cfg_of(ctrl_q, p);
				trig_rise = cfg[p].use_index ? src_rise[1] : src_rise[0];
				trig_fall = cfg[p].use_index ? src_fall[1] : src_fall[0];
				armed = cfg[p].enable && (cfg[p].continuous || !done_q[p]);
				wr_en[2 * p] = armed && cfg[p].rise_en && trig_rise;
				wr_en[2 * p + 1] = armed && cfg[p].fall_en && trig_fall;
				done_d[p] = cfg[p].enable && (done_q[p] || wr_en[2 * p] || wr_en[2 * p + 1]);
				rise_lat_d[p] = cfg[p].enable && (rise_lat_q[p] || wr_en[2 * p]);
				fall_lat_d[p] = cfg[p].enable && (fall_lat_q[p] || wr_en[2 * p + 1]);
			end
		end
	endgenerate

	always_comb begin
		status_d = 16'h0000;
		for (int p = 0; p < 2; p++) begin
			status_d[p * `PROBE_BIT_STRIDE + `STAT_ENABLE_BIT] = cfg[p].enable;
			status_d[p * `PROBE_BIT_STRIDE + `STAT_RISE_BIT] = rise_lat_d[p];
			status_d[p * `PROBE_BIT_STRIDE + `STAT_FALL_BIT] = fall_lat_d[p];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_q <= 2'h0;
			rise_lat_q <= 2'h0;
			fall_lat_q <= 2'h0;
			o_probe_status <= 16'h0000;
		end else begin
			done_q <= done_d;
			rise_lat_q <= rise_lat_d;
			fall_lat_q <= fall_lat_d;
			o_probe_status <= status_d;
		end
	end

	sequence s_single_done;
		done_q[0] && ctrl_q[0] && !ctrl_q[1];
	endsequence

	chk_single_once: assert property (s_single_done |-> wr_en[1:0] == 2'h0)
		else $error("single mode captured a second edge");
	chk_rise_capture: assert property (wr_en[0] |-> ctrl_q[0] && ctrl_q[4]
		&& (ctrl_q[2] ? src_rise[1] : src_rise[0]))
		else $error("rising capture without enabled rising edge");
	chk_fall_capture: assert property (wr_en[3] |-> ctrl_q[8] && ctrl_q[13]
		&& (ctrl_q[10] ? src_fall[1] : src_fall[0]))
		else $error("falling capture without enabled falling edge");
	chk_status_latch: assert property (wr_en[0] |=> o_probe_status[1] && o_probe_status[0])
		else $error("rising latch not shown in status");
	chk_disable_status: assert property (!ctrl_q[8] |=> o_probe_status[10:8] == 3'h0)
		else $error("disabled probe still shows status");

	// Object read: two cycles from request to answer, results from the store.
	logic [31:0] result_rd;
	logic [1:0] result_addr;
	logic [31:0] local_d, local_q;
	logic from_mem_d, from_mem_q, rd_stage_q;
	logic [2:0] result_slot;

	assign result_slot = i_obj_rd.index[2:0] - 3'h2;
	assign result_addr = result_slot[1:0];

	probe_result_mem u_results (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_en),
		.i_wr_data(i_position_feedback),
		.i_rd_addr(result_addr),
		.o_rd_data(result_rd)
	);

	always_comb begin
		local_d = 32'h0000_0000;
		from_mem_d = 1'b0;
		unique case (i_obj_rd.index)
			`OBJ_POS_OFFSET: local_d = pos_off_q;
			`OBJ_SPD_OFFSET: local_d = spd_off_q;
			`OBJ_TRQ_OFFSET: local_d = trq_off_q;
			`OBJ_CAPTURE_CTRL: local_d = {16'h0000, ctrl_q};
			`OBJ_CAPTURE_STATUS: local_d = {16'h0000, o_probe_status};
			default: from_mem_d = i_obj_rd.index >= `OBJ_RESULT_FIRST
				&& i_obj_rd.index <= `OBJ_RESULT_LAST;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			local_q <= 32'h0000_0000;
			from_mem_q <= 1'b0;
			rd_stage_q <= 1'b0;
			o_obj_rd_valid <= 1'b0;
			o_obj_rd_data <= 32'h0000_0000;
		end else begin
			local_q <= local_d;
			from_mem_q <= from_mem_d;
			rd_stage_q <= i_obj_rd.valid;
			o_obj_rd_valid <= rd_stage_q;
			o_obj_rd_data <= from_mem_q ? result_rd : local_q;
		end
	end
endmodule

// ---- tb/fieldbus_master_model.sv ----
// Fieldbus master model that issues one-cycle object write and read requests.
`timescale 1ns/10ps

module fieldbus_master_model (
	input wire logic i_core_clk,
	output probe_pkg::obj_write_t o_obj_wr,
	output probe_pkg::obj_read_t o_obj_rd
);
	initial begin
		o_obj_wr = '0;
		o_obj_rd = '0;
	end

	// Idle lines carry the inverse of the last request so a stale sample cannot pass.
	task automatic write_obj(input logic [15:0] index, input logic [31:0] data);
		@(posedge i_core_clk);
		#2 o_obj_wr = {1'b1, index, data};
		@(posedge i_core_clk);
		#2 o_obj_wr = {1'b0, ~index, ~data};
	endtask

	task automatic read_obj(input logic [15:0] index);
		@(posedge i_core_clk);
		#2 o_obj_rd = {1'b1, index};
		@(posedge i_core_clk);
		#2 o_obj_rd = {1'b0, ~index};
	endtask
endmodule

// ---- tb/tb_probe_offsets.sv ----
// Self-checking bench for the probe capture and setpoint offset block.
`timescale 1ns/10ps
`include "probe_defines.svh"

module tb_probe_offsets;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	probe_pkg::obj_write_t obj_wr;
	probe_pkg::obj_read_t obj_rd;
	logic [7:0] op_mode = 8'h00;
	logic signed [31:0] tgt_pos = 32'h0, tgt_vel = 32'h0, tgt_trq = 32'h0, feedback = 32'h0;
	logic di_four = 1'b0;
	logic enc_index = 1'b0;
	logic signed [31:0] eff_pos, eff_spd, eff_trq;
	logic [15:0] status;
	logic rd_valid;
	logic [31:0] rd_data;
	logic [31:0] expect_q[$];
	logic [31:0] offs[3];
	logic [31:0] f[7];
	logic [15:0] idxs[7] = '{16'h60b0, 16'h60b1, 16'h60b2, 16'h60b8, 16'h60b9, 16'h60bd, 16'h1234};
	logic [7:0] modes[4] = '{8'h08, 8'h09, 8'h0a, 8'h00};
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	integer seed = 32'h48759be1;

	always #12.5 i_core_clk = ~i_core_clk;

	fieldbus_master_model i_master (.i_core_clk(i_core_clk), .o_obj_wr(obj_wr), .o_obj_rd(obj_rd));

	probe_offsets i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_obj_wr(obj_wr),
		.i_obj_rd(obj_rd), .i_op_mode(op_mode), .i_target_position(tgt_pos),
		.i_target_velocity(tgt_vel), .i_target_torque(tgt_trq), .i_position_feedback(feedback),
		.i_digital_input_four(di_four), .i_encoder_index(enc_index), .o_eff_position(eff_pos),
		.o_eff_speed(eff_spd), .o_eff_torque(eff_trq), .o_probe_status(status),
		.o_obj_rd_valid(rd_valid), .o_obj_rd_data(rd_data));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic rd(input logic [15:0] index, input logic [31:0] exp);
		expect_q.push_back(exp);
		i_master.read_obj(index);
	endtask

	// The level is held eight cycles so it clears the synchroniser with margin.
	task automatic pin(input logic use_idx, input logic lvl, input logic [31:0] fb);
		@(posedge i_core_clk);
		#2 feedback = fb;
		if (use_idx) enc_index = lvl;
		else di_four = lvl;
		repeat (8) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask

	task automatic eff_case(input logic [7:0] mode);
		@(posedge i_core_clk);
		#2 op_mode = mode;
		tgt_pos = $random(seed);
		tgt_vel = $random(seed);
		tgt_trq = $random(seed);
		@(posedge i_core_clk);
		@(negedge i_core_clk);
		check(eff_pos, tgt_pos + ((mode == 8'h08) ? offs[0] : 32'h0));
		check(eff_spd, tgt_vel + ((mode == 8'h09) ? offs[1] : 32'h0));
		check(eff_trq, tgt_trq + ((mode == 8'h0a) ? offs[2] : 32'h0));
	endtask

	// Answers come back in order, so each one is matched against the oldest note.
	always @(negedge i_core_clk) begin
		if (rd_valid === 1'b1) begin
			check(32'(expect_q.size() != 0), 32'h1);
			if (expect_q.size() != 0) begin
				check(rd_data, expect_q.pop_front());
			end
		end
	end

	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			results();
		end
	end

	initial begin
		repeat (16) @(posedge i_core_clk);
		#2 i_rst_n = 1'b1;
		foreach (idxs[i]) rd(idxs[i], 32'h0);
		foreach (offs[i]) begin
			offs[i] = $random(seed);
			i_master.write_obj(`OBJ_POS_OFFSET + 16'(i), offs[i]);
			rd(`OBJ_POS_OFFSET + 16'(i), offs[i]);
		end
		i_master.write_obj(`OBJ_CAPTURE_CTRL, 32'hffff_ffff);
		rd(`OBJ_CAPTURE_CTRL, 32'h0000_ffff);
		i_master.write_obj(`OBJ_CAPTURE_STATUS, 32'h0);
		i_master.write_obj(16'h60ba, 32'h1);
		rd(`OBJ_CAPTURE_STATUS, 32'h0000_0101);
		rd(16'h60ba, 32'h0);
		foreach (modes[i]) eff_case(modes[i]);
		foreach (f[i]) f[i] = $random(seed);
		i_master.write_obj(`OBJ_CAPTURE_CTRL, 32'h0);
		i_master.write_obj(`OBJ_CAPTURE_CTRL, 32'h0000_dff9);
		pin(1'b0, 1'b1, f[0]);
		pin(1'b0, 1'b0, f[1]);
		rd(16'h60ba, f[0]);
		rd(16'h60bb, 32'h0);
		check(32'(status), 32'h0000_0103);
		pin(1'b1, 1'b1, f[2]);
		rd(16'h60bc, f[2]);
		pin(1'b1, 1'b0, f[3]);
		pin(1'b1, 1'b1, f[4]);
		rd(16'h60bc, f[4]);
		rd(16'h60bd, 32'h0);
		pin(1'b0, 1'b1, f[5]);
		rd(16'h60ba, f[0]);
		i_master.write_obj(`OBJ_CAPTURE_CTRL, 32'h0000_dff8);
		i_master.write_obj(`OBJ_CAPTURE_CTRL, 32'h0000_dff9);
		pin(1'b1, 1'b0, f[5]);
		check(32'(status), 32'h0000_0301);
		pin(1'b0, 1'b0, f[6]);
		rd(16'h60bb, f[6]);
		check(32'(status), 32'h0000_0305);
		repeat (6) @(posedge i_core_clk);
		check(32'(expect_q.size()), 32'h0);
		results();
	end
endmodule
